// file: logic/riomc_regs.vh
// Register map, field positions, reset values and timing for the IO/operation/mode register bank
//
// Function
// - IO config 2 bit 6 set switches off the digital supply regulator.
// - IO config 2 bit 4 pulls serial output down when selected and undriven.
// - IO config 2 bit 3 pulls serial output down while deselected.
// - IO config 2 bit 2 raises serial output drive strength for 1.8 V supply.
// - IO config 2 bit 0 ramps transmitter slowly, at least 10 us 10-90 percent.
// - IO config 2 and operation control reset to zero at power-up only.
// - Operation control bit 7 enables oscillator and regulator, ready state.
// - Operation control bit 6 enables or disables receive operation.
// - Operation control bit 5 selects both receive channels or one channel.
// - With both channels, bit 4 selects automatic or manual channel choice.
// - Bit 3 enables transmit; set by field-on, cleared after transmission in mode code 0000, either role.
// - Operation control bit 2 puts device into wake-up mode.
// - Mode register bit 7 selects initiator or target role.
// - Mode bits 6..3 hold operating mode code, default 0001.
// - Initiator codes select active, A, B, 212/424, type 1, subcarrier, BPSK.
// - Target codes 0000 bit rate detection, 0001 active normal mode.
// - Unsupported role and mode code disables transmit and receive.
// - Mode bit 0 starts response collision avoidance on external field off.
// - Mode register resets at power-up and on set-default command.
`ifndef RIOMC_REGS_VH
`define RIOMC_REGS_VH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define RIOMC_IDX_IO_CONFIG_SECOND  6'h01
`define RIOMC_IDX_OPERATION_CONTROL 6'h02
`define RIOMC_IDX_MODE_DEFINITION   6'h03
`define RIOMC_IDX_STATUS            6'h04

// ------------------------------------------------------------
// Writable masks and reset values
// ------------------------------------------------------------
`define RIOMC_IO2_MASK   8'hdd
`define RIOMC_OPC_MASK   8'hfc
`define RIOMC_MODE_MASK  8'hf9
`define RIOMC_IO2_RST    8'h00
`define RIOMC_OPC_RST    8'h00
`define RIOMC_MODE_RST   8'h08

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define RIOMC_IO2_SUPPLY_RANGE  7
`define RIOMC_IO2_REG_OFF       6
`define RIOMC_IO2_PD_SELECTED   4
`define RIOMC_IO2_PD_DESELECTED 3
`define RIOMC_IO2_DRIVE_HIGH    2
`define RIOMC_IO2_SLOW_RAMP     0
`define RIOMC_OPC_READY         7
`define RIOMC_OPC_RX_EN         6
`define RIOMC_OPC_ONE_CHANNEL   5
`define RIOMC_OPC_MANUAL_CHAN   4
`define RIOMC_OPC_TX_EN         3
`define RIOMC_OPC_WAKEUP        2
`define RIOMC_MODE_TARGET       7
`define RIOMC_MODE_CODE_MSB     6
`define RIOMC_MODE_CODE_LSB     3
`define RIOMC_MODE_AUTO_CA      0

// ------------------------------------------------------------
// Operating mode codes
// ------------------------------------------------------------
`define RIOMC_OM_ACTIVE     4'h0
`define RIOMC_OM_TYPE_A     4'h1
`define RIOMC_OM_TYPE_B     4'h2
`define RIOMC_OM_CARD_2XX   4'h3
`define RIOMC_OM_TYPE1_TAG  4'h4
`define RIOMC_OM_SUBCARRIER 4'he
`define RIOMC_OM_BPSK       4'hf

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define RIOMC_CLK_MHZ        40
`define RIOMC_SLOW_RAMP_US   10
`define RIOMC_SLOW_RAMP_CYC  (`RIOMC_SLOW_RAMP_US * `RIOMC_CLK_MHZ)

`endif

// file: logic/riomc_ramp.v
// Transmitter ramp controller: immediate or slow rise of the transmit drive
`timescale 1ns/100ps
module riomc_ramp #(
	parameter STEPS     = 8,
	parameter SLOW_CYC  = 400
) (
	// Clock and reset
	input  wire       clk,
	input  wire       srst,
	// Control
	input  wire       tx_on,
	input  wire       slow,
	// Drive level, 0 to STEPS
	output reg  [3:0] level_r,
	output reg        full_r
);
	// Rounded up so the full rise never beats the least ramp time
	localparam [15:0] STEP_CYC = (SLOW_CYC + STEPS - 1) / STEPS;

	reg [15:0] div_r;
	wire       tick = (div_r == 16'h0001);

	always @(posedge clk) begin
		if (srst) begin
			div_r   <= 16'h0000;
			level_r <= 4'h0;
			full_r  <= 1'b0;
		end else begin
			if (!tx_on) begin
				level_r <= 4'h0;
				div_r   <= STEP_CYC;
			end else if (!slow) begin
				level_r <= STEPS[3:0];
			end else if (level_r != STEPS[3:0]) begin
				if (tick) begin
					level_r <= level_r + 4'h1;
					div_r   <= STEP_CYC;
				end else begin
					div_r <= div_r - 16'h0001;
				end
			end
			full_r <= tx_on && (level_r == STEPS[3:0]);
		end
	end
endmodule // riomc_ramp

// file: logic/riomc_top.v
// IO configuration, operation control and mode definition register bank
//
// Register access over Wishbone was decided locally.
`timescale 1ns/100ps
`include "riomc_regs.vh"
module riomc_top #(
	parameter RAMP_STEPS = 8
) (
	// Clock and reset
	input  wire        clk,
	input  wire        srst,
	// Wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	output reg         wb_err_o,
	// Device events (same clock)
	input  wire        set_default_cmd,
	input  wire        field_on_cmd,
	input  wire        tx_done,
	input  wire        ext_field_off,
	input  wire        xtal_stable,
	// Serial port pin states
	input  wire        sdo_chip_select_n,
	input  wire        sdo_driving,
	// Power and analog control
	output reg         digital_supply_rail_off_r,
	output reg         supply_range_select_r,
	output reg         osc_regulator_en_r,
	output reg         ready_r,
	output reg         sdo_pulldown_en_r,
	output reg         sdo_drive_high_r,
	// Receiver and transmitter control
	output reg         rx_active_r,
	output reg         rx_one_channel_r,
	output reg         rx_manual_choice_r,
	output reg         tx_active_r,
	output reg  [3:0]  tx_ramp_level_r,
	output reg         wakeup_enable_r,
	// Mode
	output reg         target_role_r,
	output reg  [3:0]  operating_mode_code_r,
	output reg         mode_supported_r,
	output reg         collision_avoid_start_r
);
	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	reg [7:0] io_config_second_r;
	reg [7:0] operation_control_r;
	reg [7:0] mode_definition_r;
	reg [7:0] io_config_second_nxt;
	reg [7:0] operation_control_nxt;
	reg [7:0] mode_definition_nxt;
	reg       ca_pending_r;
	// Chip select comes from the host pin, so it is brought in over two stages
	reg       cs_n_meta_r;
	reg       cs_n_sync_r;

	always @(posedge clk) begin
		if (srst) begin
			cs_n_meta_r <= 1'b1;
			cs_n_sync_r <= 1'b1;
		end else begin
			cs_n_meta_r <= sdo_chip_select_n;
			cs_n_sync_r <= cs_n_meta_r;
		end
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function [7:0] merge;
		input [7:0] old_v;
		input [7:0] new_v;
		input [7:0] mask;
		begin
			merge = (new_v & mask) | (old_v & ~mask);
			merge = merge & mask;
		end
	endfunction

	function supported;
		input       targ;
		input [3:0] code;
		begin
			if (!targ) begin
				case (code)
					`RIOMC_OM_ACTIVE, `RIOMC_OM_TYPE_A, `RIOMC_OM_TYPE_B,
					`RIOMC_OM_CARD_2XX, `RIOMC_OM_TYPE1_TAG,
					`RIOMC_OM_SUBCARRIER, `RIOMC_OM_BPSK: supported = 1'b1;
					default: supported = 1'b0;
				endcase
			end else begin
				case (code)
					`RIOMC_OM_ACTIVE, `RIOMC_OM_TYPE_A: supported = 1'b1;
					default: supported = 1'b0;
				endcase
			end
		end
	endfunction

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	wire       req    = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	wire [5:0] idx    = wb_adr_i[7:2];
	wire       hit_io = (idx == `RIOMC_IDX_IO_CONFIG_SECOND);
	wire       hit_op = (idx == `RIOMC_IDX_OPERATION_CONTROL);
	wire       hit_md = (idx == `RIOMC_IDX_MODE_DEFINITION);
	wire       hit_st = (idx == `RIOMC_IDX_STATUS);
	wire       mapped = hit_io || hit_op || hit_md || hit_st;
	wire       wr_b0  = req && wb_we_i && wb_sel_i[0];

	wire       code_ok = supported(mode_definition_r[`RIOMC_MODE_TARGET],
		mode_definition_r[`RIOMC_MODE_CODE_MSB:`RIOMC_MODE_CODE_LSB]);
	wire [3:0] ramp_level;
	wire       ramp_full;

	// ------------------------------------------------------------
	// Next register values
	// ------------------------------------------------------------
	always @* begin
		io_config_second_nxt  = io_config_second_r;
		operation_control_nxt = operation_control_r;
		mode_definition_nxt   = mode_definition_r;
		if (wr_b0 && hit_io)
			io_config_second_nxt = merge(io_config_second_r, wb_dat_i[7:0],
				`RIOMC_IO2_MASK);
		if (wr_b0 && hit_op)
			operation_control_nxt = merge(operation_control_r, wb_dat_i[7:0],
				`RIOMC_OPC_MASK);
		if (wr_b0 && hit_md)
			mode_definition_nxt = merge(mode_definition_r, wb_dat_i[7:0],
				`RIOMC_MODE_MASK);
		if (tx_done && (mode_definition_r[`RIOMC_MODE_CODE_MSB:`RIOMC_MODE_CODE_LSB]
				== `RIOMC_OM_ACTIVE))
			operation_control_nxt[`RIOMC_OPC_TX_EN] = 1'b0;
		// field-on set wins over any clear
		if (field_on_cmd)
			operation_control_nxt[`RIOMC_OPC_TX_EN] = 1'b1;
		if (set_default_cmd)
			mode_definition_nxt = `RIOMC_MODE_RST;
	end

	// ------------------------------------------------------------
	// Register state and bus answer
	// ------------------------------------------------------------
	always @(posedge clk) begin
		if (srst) begin
			io_config_second_r  <= `RIOMC_IO2_RST;
			operation_control_r <= `RIOMC_OPC_RST;
			mode_definition_r   <= `RIOMC_MODE_RST;
			wb_ack_o            <= 1'b0;
			wb_err_o            <= 1'b0;
			wb_dat_o            <= 32'h0000_0000;
		end else begin
			io_config_second_r  <= io_config_second_nxt;
			operation_control_r <= operation_control_nxt;
			mode_definition_r   <= mode_definition_nxt;
			wb_ack_o            <= req && mapped;
			wb_err_o            <= req && !mapped;
			wb_dat_o            <= 32'h0000_0000;
			if (req && !wb_we_i) begin
				if (hit_io)
					wb_dat_o[7:0] <= io_config_second_r & `RIOMC_IO2_MASK;
				if (hit_op)
					wb_dat_o[7:0] <= operation_control_r & `RIOMC_OPC_MASK;
				if (hit_md)
					wb_dat_o[7:0] <= mode_definition_r & `RIOMC_MODE_MASK;
				if (hit_st)
					wb_dat_o[7:0] <= {ready_r, rx_active_r, tx_active_r,
						ramp_full, mode_supported_r, ca_pending_r,
						collision_avoid_start_r, wakeup_enable_r};
			end
		end
	end

	// ------------------------------------------------------------
	// Transmit ramp
	// ------------------------------------------------------------
	wire tx_request = operation_control_r[`RIOMC_OPC_TX_EN] && code_ok &&
		ready_r;

	// slow ramp at least the minimum rise time
	riomc_ramp #(
		.STEPS    (RAMP_STEPS),
		.SLOW_CYC (`RIOMC_SLOW_RAMP_CYC)
	) u_ramp (
		.clk     (clk),
		.srst    (srst),
		.tx_on   (tx_request),
		.slow    (io_config_second_r[`RIOMC_IO2_SLOW_RAMP]),
		.level_r (ramp_level),
		.full_r  (ramp_full)
	);

	// ------------------------------------------------------------
	// Control outputs
	// ------------------------------------------------------------
	always @(posedge clk) begin
		if (srst) begin
			digital_supply_rail_off_r <= 1'b0;
			supply_range_select_r     <= 1'b0;
			osc_regulator_en_r        <= 1'b0;
			ready_r                   <= 1'b0;
			sdo_pulldown_en_r         <= 1'b0;
			sdo_drive_high_r          <= 1'b0;
			rx_active_r               <= 1'b0;
			rx_one_channel_r          <= 1'b0;
			rx_manual_choice_r        <= 1'b0;
			tx_active_r               <= 1'b0;
			tx_ramp_level_r           <= 4'h0;
			wakeup_enable_r           <= 1'b0;
			target_role_r             <= 1'b0;
			operating_mode_code_r     <= 4'h1;
			mode_supported_r          <= 1'b1;
			collision_avoid_start_r   <= 1'b0;
			ca_pending_r              <= 1'b0;
		end else begin
			digital_supply_rail_off_r <= io_config_second_r[`RIOMC_IO2_REG_OFF];
			supply_range_select_r     <= io_config_second_r[`RIOMC_IO2_SUPPLY_RANGE];
			sdo_pulldown_en_r <=
				(io_config_second_r[`RIOMC_IO2_PD_SELECTED] &&
				!cs_n_sync_r && !sdo_driving) ||
				(io_config_second_r[`RIOMC_IO2_PD_DESELECTED] &&
				cs_n_sync_r);
			sdo_drive_high_r <= io_config_second_r[`RIOMC_IO2_DRIVE_HIGH];
			// oscillator and regulator, ready once stable
			osc_regulator_en_r <= operation_control_r[`RIOMC_OPC_READY];
			ready_r <= operation_control_r[`RIOMC_OPC_READY] && xtal_stable;
			rx_active_r <= operation_control_r[`RIOMC_OPC_RX_EN] && code_ok &&
				ready_r;
			rx_one_channel_r <= operation_control_r[`RIOMC_OPC_ONE_CHANNEL];
			// manual choice only with both channels
			rx_manual_choice_r <= !operation_control_r[`RIOMC_OPC_ONE_CHANNEL] &&
				operation_control_r[`RIOMC_OPC_MANUAL_CHAN];
			tx_active_r     <= tx_request;
			tx_ramp_level_r <= ramp_level;
			wakeup_enable_r <= operation_control_r[`RIOMC_OPC_WAKEUP];
			target_role_r <= mode_definition_r[`RIOMC_MODE_TARGET];
			operating_mode_code_r <=
				mode_definition_r[`RIOMC_MODE_CODE_MSB:`RIOMC_MODE_CODE_LSB];
			mode_supported_r <= code_ok;
			// one pulse per field-off while armed
			collision_avoid_start_r <= ext_field_off &&
				mode_definition_r[`RIOMC_MODE_AUTO_CA];
			// Sticky until next set-up write, shows a sequence was started
			if (ext_field_off && mode_definition_r[`RIOMC_MODE_AUTO_CA])
				ca_pending_r <= 1'b1;
			else if (wr_b0 && hit_md)
				ca_pending_r <= 1'b0;
		end
	end
endmodule // riomc_top

// file: verification/riomc_top_props.sv
// Bus and control output checker for the register bank
`timescale 1ns/100ps
module riomc_chk #(
	parameter RAMP_STEPS = 8
) (
	// Clock and reset
	input wire        clk,
	input wire        srst,
	// Bus
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire [31:0] wb_dat_o,
	input wire        wb_ack_o,
	input wire        wb_err_o,
	// Events
	input wire        set_default_cmd,
	input wire        ext_field_off,
	input wire        xtal_stable,
	// Watched outputs
	input wire        osc_regulator_en_r,
	input wire        ready_r,
	input wire        rx_active_r,
	input wire        tx_active_r,
	input wire [3:0]  tx_ramp_level_r,
	input wire        target_role_r,
	input wire [3:0]  operating_mode_code_r,
	input wire        mode_supported_r,
	input wire        collision_avoid_start_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	a_ack_after_req: assert property (
		(wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o) |=> (wb_ack_o || wb_err_o))
		else $error("request not answered in one cycle");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_idle_no_ack: assert property (
		!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o)
		else $error("answer without request");
	a_read_upper_zero: assert property (wb_dat_o[31:8] == 24'h0)
		else $error("read data upper bits set");
	a_ready_needs_xtal: assert property (ready_r |-> $past(xtal_stable))
		else $error("ready without stable oscillator");
	a_rx_needs_osc: assert property (
		rx_active_r |-> (osc_regulator_en_r || $past(osc_regulator_en_r)))
		else $error("receive active with oscillator off");
	a_tx_needs_mode: assert property (
		tx_active_r |-> (mode_supported_r || $past(mode_supported_r)))
		else $error("transmit active in unsupported mode");
	a_rx_needs_mode: assert property (
		rx_active_r |-> (mode_supported_r || $past(mode_supported_r)))
		else $error("receive active in unsupported mode");
	a_ca_cause: assert property (collision_avoid_start_r |-> $past(ext_field_off))
		else $error("collision avoidance start without field off");
	a_ramp_range: assert property (tx_ramp_level_r <= RAMP_STEPS)
		else $error("ramp level beyond full");
	a_ramp_idle: assert property (!tx_active_r [*3] |-> tx_ramp_level_r == 4'h0)
		else $error("ramp level while transmit off");
	a_default_mode: assert property (
		set_default_cmd |-> ##2 (operating_mode_code_r == 4'h1 && !target_role_r))
		else $error("mode not restored by set default");
endmodule // riomc_chk

bind riomc_top riomc_chk #(.RAMP_STEPS(RAMP_STEPS)) u_riomc_chk (.*);

// file: verification/riomc_host.sv
// Bus master standing in for the host controller
`timescale 1ns/100ps
module riomc_host (
	// Clock
	input  wire         clk,
	// Request
	output logic        wb_cyc_i = 1'b0,
	output logic        wb_stb_i = 1'b0,
	output logic        wb_we_i = 1'b0,
	output logic [7:0]  wb_adr_i = 8'h00,
	output logic [3:0]  wb_sel_i = 4'h0,
	output logic [31:0] wb_dat_i = 32'h0,
	// Answer
	input  wire [31:0]  wb_dat_o,
	input  wire         wb_ack_o,
	input  wire         wb_err_o
);
	// Idle address and data lines carry inverted values so stale data never looks valid
	task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge clk);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, s, d};
		@(posedge clk);
		while (!(wb_ack_o || wb_err_o))
			@(posedge clk);
		q = wb_dat_o;
		e = wb_err_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		wb_adr_i <= ~a;
		wb_dat_i <= ~d;
	endtask
endmodule // riomc_host

// file: verification/tb.sv
// Self-checking bench for the register bank
`timescale 1ns/100ps
`define CHK(n, e, s) ck(n, e, s)
module tb;
	logic clk = 1'b0, srst = 1'b1, sdo_chip_select_n = 1'b1, sdo_driving = 1'b0;
	logic xtal_stable = 1'b1, e, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o;
	logic digital_supply_rail_off_r, supply_range_select_r, osc_regulator_en_r;
	logic ready_r, sdo_pulldown_en_r, sdo_drive_high_r, rx_active_r, tx_active_r;
	logic rx_one_channel_r, rx_manual_choice_r, wakeup_enable_r, target_role_r;
	logic mode_supported_r, collision_avoid_start_r;
	logic [3:0] ev = 4'h0, wb_sel_i, tx_ramp_level_r, operating_mode_code_r;
	logic [7:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	int err_total = 0, checks_done = 0, n;
	wire set_default_cmd = ev[0], field_on_cmd = ev[1], tx_done = ev[2];
	wire ext_field_off = ev[3];
	// Address, write value, expected read
	logic [23:0] regs [6] = '{24'h04ffdd, 24'h042200, 24'h08fffc, 24'h080300,
		24'h0cfff9, 24'h0c0600};
	// Mode byte, supported
	logic [8:0] modes [11] = '{9'h001, 9'h011, 9'h021, 9'h031, 9'h041, 9'h0e1,
		9'h0f1, 9'h050, 9'h101, 9'h111, 9'h120};

	riomc_top #(.RAMP_STEPS(8)) u_riomc_top (.*);
	riomc_host u_riomc_host (.*);

	initial forever #12.5 clk = ~clk;
	initial begin
		#250000;
		err_total++;
		summarize();
	end

	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic ck(input string nm, input logic [7:0] x, input logic [7:0] s);
		checks_done++;
		if (s !== x) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_riomc_host.acc(1'b1, a, 4'h1, {24'h0, d}, q, e);
	endtask
	task automatic rd(input logic [7:0] a);
		u_riomc_host.acc(1'b0, a, 4'hf, 32'h0, q, e);
	endtask
	task automatic settle;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic pulse(input int k);
		@(posedge clk);
		ev[k] <= 1'b1;
		@(posedge clk);
		ev <= 4'h0;
		#1;
	endtask
	task automatic ramp_time;
		n = 0;
		while (tx_ramp_level_r !== 4'h8 && n < 1000) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask

	initial begin
		repeat (4) @(posedge clk);
		`CHK("reset mode code", 8'h01, operating_mode_code_r);
		`CHK("reset ready", 8'h00, ready_r);
		srst <= 1'b0;
		for (int i = 1; i < 4; i++) begin
			rd(8'(i * 4));
			`CHK("reset value", (i == 3) ? 8'h08 : 8'h00, q[7:0]);
		end
		for (int i = 0; i < 6; i++) begin
			wr(regs[i][23:16], regs[i][15:8]);
			rd(regs[i][23:16]);
			`CHK("readback", regs[i][7:0], q[7:0]);
		end
		$display("register table done");
		wr(8'h04, 8'hdd);
		settle();
		`CHK("regulator off", 8'h01, digital_supply_rail_off_r);
		`CHK("drive high", 8'h01, sdo_drive_high_r);
		`CHK("supply range", 8'h01, supply_range_select_r);
		for (int i = 0; i < 8; i++) begin
			wr(8'h04, i[2] ? 8'h10 : 8'h08);
			sdo_chip_select_n <= i[1];
			sdo_driving <= i[0];
			settle();
			`CHK("pulldown", i[2] ? !(i[1] | i[0]) : i[1], sdo_pulldown_en_r);
		end
		$display("pin control done");
		wr(8'h08, 8'hf4);
		settle();
		`CHK("ready", 8'h01, ready_r);
		`CHK("osc enable", 8'h01, osc_regulator_en_r);
		`CHK("one channel", 8'h01, rx_one_channel_r);
		`CHK("manual ignored", 8'h00, rx_manual_choice_r);
		`CHK("wakeup", 8'h01, wakeup_enable_r);
		wr(8'h08, 8'hd0);
		settle();
		`CHK("manual", 8'h01, rx_manual_choice_r);
		`CHK("receive", 8'h01, rx_active_r);
		wr(8'h08, 8'hc8);
		for (int i = 0; i < 11; i++) begin
			wr(8'h0c, modes[i][8:1]);
			settle();
			`CHK("role", modes[i][8], target_role_r);
			`CHK("code", modes[i][7:4], operating_mode_code_r);
			`CHK("supported", modes[i][0], mode_supported_r);
			`CHK("tx gated", modes[i][0], tx_active_r);
			`CHK("rx gated", modes[i][0], rx_active_r);
		end
		$display("mode table done");
		for (int i = 0; i < 2; i++) begin
			wr(8'h0c, i[0] ? 8'h08 : 8'h00);
			wr(8'h08, 8'hc0);
			pulse(1);
			rd(8'h08);
			`CHK("field on", 8'hc8, q[7:0]);
			pulse(2);
			rd(8'h08);
			`CHK("tx done", i[0] ? 8'hc8 : 8'hc0, q[7:0]);
		end
		for (int i = 0; i < 2; i++) begin
			wr(8'h0c, {7'h01, i[0]});
			pulse(3);
			`CHK("collision avoid", i[0], collision_avoid_start_r);
		end
		wr(8'h0c, 8'h91);
		pulse(0);
		rd(8'h0c);
		`CHK("set default mode", 8'h08, q[7:0]);
		rd(8'h08);
		`CHK("opc kept", 8'hc8, q[7:0]);
		rd(8'h04);
		`CHK("io kept", 8'h10, q[7:0]);
		$display("commands done");
		wr(8'h08, 8'h80);
		wr(8'h04, 8'h01);
		pulse(1);
		ramp_time();
		`CHK("slow ramp", 8'h01, 8'(n >= 400));
		wr(8'h08, 8'h80);
		wr(8'h04, 8'h00);
		settle();
		`CHK("ramp off", 8'h00, tx_ramp_level_r);
		pulse(1);
		ramp_time();
		`CHK("fast ramp", 8'h01, 8'(n < 4));
		xtal_stable <= 1'b0;
		settle();
		`CHK("ready needs xtal", 8'h00, ready_r);
		xtal_stable <= 1'b1;
		settle();
		`CHK("ready back", 8'h01, ready_r);
		u_riomc_host.acc(1'b0, 8'h40, 4'hf, 32'h0, q, e);
		`CHK("unmapped", 8'h01, e);
		u_riomc_host.acc(1'b1, 8'h04, 4'h0, 32'hff, q, e);
		rd(8'h04);
		`CHK("sel ignored", 8'h00, q[7:0]);
		$display("ramp and bus done");
		summarize();
	end
endmodule // tb
